// [shared/jtag_config_tap_map.vh]
// constants for the configuration test access port: widths,
// instruction codes and reset values.
// assumes inclusion by bare name from the rtl file.
`ifndef JTAG_CONFIG_TAP_MAP_VH
`define JTAG_CONFIG_TAP_MAP_VH

// register lengths
`define IR_LEN 5
`define ID_LEN 32
`define CFG_LEN 109
`define STATE_W 4

// instruction codes
`define EXTEST_INSTR 5'h00
`define SELECT_CONFIG_REG_INSTR 5'h01
`define ERASE_ALL_CONFIG_INSTR 5'h02
`define VERIFY_CONFIG_INSTR 5'h03
`define PROGRAM_CONFIG_INSTR 5'h04
`define IDCODE_INSTR 5'h0d
`define START_CALIBRATION_INSTR 5'h10
`define SAMPLE_PRELOAD_INSTR 5'h1e
`define BYPASS_INSTR 5'h1f

// identification word; value is arbitrary, bit 0 must stay one
`define ID_WORD 32'h0a5c3001

// reset values
`define BYPASS_CAPTURE 1'b0
`define TDO_IDLE 1'b0

`endif

// [rtl/jtag_config_tap.v]
// configuration test access port: tap controller, instruction,
// bypass, identification and configuration shift registers.
// assumes tck/tms/tdi/trst_n come from an external host at a rate
// well below ref_clk; nv_cfg comes from logic on ref_clk.
//
// What this block does
// - sixteen-state controller stepped by tck, tms-steered
// - sample on tck rise, drive tdo on fall
// - tms high reaches test-logic-reset within five clocks
// - trst_n low forces test-logic-reset without tck
// - power-on starts in test-logic-reset
// - test-logic-reset leads to idle; idle does nothing
// - capture-dr loads bypass or identification; configuration register keeps contents
// - capture-ir loads idcode; idcode selected after reset
// - capture to shift or exit1, then update/pause
// - pause resumes via exit2; contents held while paused
// - program, erase, verify, calibrate start on next idle entry
// - other instructions take effect in update
// - five-bit instruction selects path and operation
// - all-ones bypass selects bypass, device undisturbed
// - bypass is a single shift stage
// - boundary instructions behave exactly as bypass
// - select, shift, program moves data into cells
// - verify shifts configuration out on tdo
// - select 00001, verify 00011, program 00100
// - idcode 01101, calibrate 10000, sample 11110, erase 00010
// - configuration register has 109 stages
// - identification register has 32 stages
`timescale 1ns/1ps
`include "jtag_config_tap_map.vh"

module jtag_config_tap
(
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // test port pins
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trst_n,
    output wire tdo,
    output wire tdo_oe,
    // configuration side
    input wire [`CFG_LEN-1:0] nv_cfg,
    output wire [`CFG_LEN-1:0] cfg_data,
    output wire program_start,
    output wire erase_start,
    output wire verify_start,
    output wire calibrate_start,
    // status
    output wire [`IR_LEN-1:0] active_instr,
    output wire [`STATE_W-1:0] tap_state
);

////////////////////////////////////////////////////////////////////////
// controller states

localparam [3:0] ST_RESET = 4'h0;
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_SEL_DR = 4'h2;
localparam [3:0] ST_CAP_DR = 4'h3;
localparam [3:0] ST_SH_DR = 4'h4;
localparam [3:0] ST_EX1_DR = 4'h5;
localparam [3:0] ST_PA_DR = 4'h6;
localparam [3:0] ST_EX2_DR = 4'h7;
localparam [3:0] ST_UP_DR = 4'h8;
localparam [3:0] ST_SEL_IR = 4'h9;
localparam [3:0] ST_CAP_IR = 4'ha;
localparam [3:0] ST_SH_IR = 4'hb;
localparam [3:0] ST_EX1_IR = 4'hc;
localparam [3:0] ST_PA_IR = 4'hd;
localparam [3:0] ST_EX2_IR = 4'he;
localparam [3:0] ST_UP_IR = 4'hf;

// data path selected by an instruction
localparam [1:0] PATH_BYP = 2'h0;
localparam [1:0] PATH_ID = 2'h1;
localparam [1:0] PATH_CFG = 2'h2;

function [3:0] next_state;
    input [3:0] st;
    input m;
    begin
        case (st)
            ST_RESET: next_state = m ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_state = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = m ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: next_state = m ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_state = m ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: next_state = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_state = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = m ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: next_state = m ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_state = m ? ST_UP_IR : ST_SH_IR;
            ST_UP_IR: next_state = m ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end
endfunction

// unknown and boundary codes fall through to bypass
function [1:0] path_of;
    input [`IR_LEN-1:0] ins;
    begin
        case (ins)
            `IDCODE_INSTR: path_of = PATH_ID;
            `SELECT_CONFIG_REG_INSTR: path_of = PATH_CFG;
            `VERIFY_CONFIG_INSTR: path_of = PATH_CFG;
            `PROGRAM_CONFIG_INSTR: path_of = PATH_CFG;
            default: path_of = PATH_BYP;
        endcase
    end
endfunction

function is_deferred;
    input [`IR_LEN-1:0] ins;
    begin
        case (ins)
            `PROGRAM_CONFIG_INSTR: is_deferred = 1'b1;
            `ERASE_ALL_CONFIG_INSTR: is_deferred = 1'b1;
            `VERIFY_CONFIG_INSTR: is_deferred = 1'b1;
            `START_CALIBRATION_INSTR: is_deferred = 1'b1;
            default: is_deferred = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// reset release and pin synchronisers

reg [1:0] rst_sync_r;
reg tck_s1_r, tck_s2_r, tck_prev_r;
reg tms_s1_r, tms_s2_r;
reg tdi_s1_r, tdi_s2_r;
reg trst_s1_r, trst_s2_r;
wire rst_sync_n = rst_sync_r[1];

always @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
        rst_sync_r <= 2'h0;
    else
        rst_sync_r <= {rst_sync_r[0], 1'b1};
end

always @(posedge ref_clk or negedge rst_sync_n)
begin
    if (!rst_sync_n)
    begin
        tck_s1_r <= 1'b0;
        tck_s2_r <= 1'b0;
        tck_prev_r <= 1'b0;
        tms_s1_r <= 1'b1;
        tms_s2_r <= 1'b1;
        tdi_s1_r <= 1'b0;
        tdi_s2_r <= 1'b0;
        // starts asserted so the port begins in reset state
        trst_s1_r <= 1'b0;
        trst_s2_r <= 1'b0;
    end
    else
    begin
        tck_s1_r <= tck;
        tck_s2_r <= tck_s1_r;
        tck_prev_r <= tck_s2_r;
        tms_s1_r <= tms;
        tms_s2_r <= tms_s1_r;
        tdi_s1_r <= tdi;
        tdi_s2_r <= tdi_s1_r;
        trst_s1_r <= trst_n;
        trst_s2_r <= trst_s1_r;
    end
end

wire tck_rise = tck_s2_r & ~tck_prev_r;
wire tck_fall = ~tck_s2_r & tck_prev_r;

////////////////////////////////////////////////////////////////////////
// controller and shift paths

reg [3:0] state_r;
reg [`IR_LEN-1:0] ir_sh_r, ir_r;
reg byp_r;
reg [`ID_LEN-1:0] id_sh_r;
reg [`CFG_LEN-1:0] cfg_r;
reg pend_r;
reg tdo_r, tdo_oe_r;
reg prog_r, erase_r, verify_r, cal_r;
wire [1:0] path = path_of(ir_r);
wire [3:0] state_nxt = next_state(state_r, tms_s2_r);
// leaving test-logic-reset starts nothing: that state cancels pending work
wire enter_idle = tck_rise & (state_nxt == ST_IDLE) &
    (state_r != ST_IDLE) & (state_r != ST_RESET);

always @(posedge ref_clk or negedge rst_sync_n)
begin
    if (!rst_sync_n)
    begin
        state_r <= ST_RESET;
        ir_sh_r <= `IDCODE_INSTR;
        ir_r <= `IDCODE_INSTR;
        byp_r <= `BYPASS_CAPTURE;
        id_sh_r <= `ID_WORD;
        cfg_r <= {`CFG_LEN{1'b0}};
        pend_r <= 1'b0;
        prog_r <= 1'b0;
        erase_r <= 1'b0;
        verify_r <= 1'b0;
        cal_r <= 1'b0;
    end
    else if (!trst_s2_r)
    begin
        // no tck edge needed; pending work is dropped
        state_r <= ST_RESET;
        ir_r <= `IDCODE_INSTR;
        pend_r <= 1'b0;
        prog_r <= 1'b0;
        erase_r <= 1'b0;
        verify_r <= 1'b0;
        cal_r <= 1'b0;
    end
    else
    begin
        prog_r <= 1'b0;
        erase_r <= 1'b0;
        verify_r <= 1'b0;
        cal_r <= 1'b0;
        if (tck_rise)
        begin
            state_r <= state_nxt;
            case (state_r)
                ST_CAP_IR: ir_sh_r <= `IDCODE_INSTR;
                ST_SH_IR: ir_sh_r <= {tdi_s2_r, ir_sh_r[`IR_LEN-1:1]};
                ST_CAP_DR:
                begin
                    // configuration path keeps its contents so that
                    // verify data survives until shifted out
                    if (path == PATH_ID)
                        id_sh_r <= `ID_WORD;
                    else if (path == PATH_BYP)
                        byp_r <= `BYPASS_CAPTURE;
                end
                ST_SH_DR:
                begin
                    if (path == PATH_ID)
                        id_sh_r <= {tdi_s2_r, id_sh_r[`ID_LEN-1:1]};
                    else if (path == PATH_CFG)
                        cfg_r <= {tdi_s2_r, cfg_r[`CFG_LEN-1:1]};
                    else
                        byp_r <= tdi_s2_r;
                end
                ST_RESET:
                begin
                    ir_r <= `IDCODE_INSTR;
                    pend_r <= 1'b0;
                end
                default:
                begin
                end
            endcase
            // deferred work fires once, on the idle entry after loading
            if (enter_idle && pend_r)
            begin
                pend_r <= 1'b0;
                case (ir_r)
                    `PROGRAM_CONFIG_INSTR: prog_r <= 1'b1;
                    `ERASE_ALL_CONFIG_INSTR: erase_r <= 1'b1;
                    `VERIFY_CONFIG_INSTR: verify_r <= 1'b1;
                    `START_CALIBRATION_INSTR: cal_r <= 1'b1;
                    default: pend_r <= 1'b0;
                endcase
            end
        end
        else if (tck_fall && state_r == ST_UP_IR)
        begin
            ir_r <= ir_sh_r;
            pend_r <= is_deferred(ir_sh_r);
        end
        // verify loads cells into the register for a later shift out
        if (verify_r)
            cfg_r <= nv_cfg;
    end
end

////////////////////////////////////////////////////////////////////////
// serial output, changed on the falling tck edge or cleared while trst_n is low

always @(posedge ref_clk or negedge rst_sync_n)
begin
    if (!rst_sync_n)
    begin
        tdo_r <= `TDO_IDLE;
        tdo_oe_r <= 1'b0;
    end
    else if (!trst_s2_r)
    begin
        tdo_r <= `TDO_IDLE;
        tdo_oe_r <= 1'b0;
    end
    else if (tck_fall)
    begin
        tdo_oe_r <= (state_r == ST_SH_IR) | (state_r == ST_SH_DR);
        if (state_r == ST_SH_IR)
            tdo_r <= ir_sh_r[0];
        else if (path == PATH_ID)
            tdo_r <= id_sh_r[0];
        else if (path == PATH_CFG)
            tdo_r <= cfg_r[0];
        else
            tdo_r <= byp_r;
    end
end

assign tdo = tdo_r;
assign tdo_oe = tdo_oe_r;
assign cfg_data = cfg_r;
assign program_start = prog_r;
assign erase_start = erase_r;
assign verify_start = verify_r;
assign calibrate_start = cal_r;
assign active_instr = ir_r;
assign tap_state = state_r;

endmodule // jtag_config_tap

// [testbench/jtag_config_tap_asserts.sv]
// checker for the configuration test access port, bound to its ports.
// assumes tck is held low around trst_n pulses by the host.
`timescale 1ns/1ps
`include "jtag_config_tap_map.vh"
module jtag_config_tap_asserts
(
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // test port pins
    input wire tck,
    input wire trst_n,
    input wire tdo,
    input wire tdo_oe,
    // configuration side
    input wire [`CFG_LEN-1:0] nv_cfg,
    input wire [`CFG_LEN-1:0] cfg_data,
    input wire program_start,
    input wire erase_start,
    input wire verify_start,
    // status
    input wire [`IR_LEN-1:0] active_instr,
    input wire [`STATE_W-1:0] tap_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    oe_shift_a: assert property (tdo_oe |->
        tap_state inside {4'h4, 4'h5, 4'hb, 4'hc}) else $error("tdo driven");
    // detection lags the pin by three edges, well inside a tck phase
    tdo_fall_a: assert property (tdo != $past(tdo) |-> !tck)
        else $error("tdo moved with tck high");
    step_rise_a: assert property (tap_state != $past(tap_state) |->
        tck || tap_state == 4'h0) else $error("state moved with tck low");
    trst_tlr_a: assert property ($fell(trst_n) |-> ##[1:4]
        (tap_state == 4'h0 && active_instr == `IDCODE_INSTR))
        else $error("test reset ignored");
    tlr_idle_a: assert property ($past(tap_state) == 4'h0 &&
        tap_state != 4'h0 |-> tap_state == 4'h1) else $error("left reset");
    prog_idle_a: assert property (program_start |-> tap_state == 4'h1 &&
        active_instr == `PROGRAM_CONFIG_INSTR ##1 !program_start)
        else $error("program pulse wrong");
    erase_idle_a: assert property (erase_start |->
        $past(tap_state) != 4'h1 && tap_state == 4'h1 &&
        active_instr == `ERASE_ALL_CONFIG_INSTR) else $error("erase pulse");
    verify_load_a: assert property (verify_start |=>
        cfg_data == nv_cfg) else $error("verify did not load");
    pause_hold_a: assert property (tap_state == 4'h6 |=>
        $stable(cfg_data)) else $error("data moved in pause");
    cover property (program_start);
    cover property (verify_start);
    cover property (tap_state == 4'h6);
endmodule // jtag_config_tap_asserts

bind jtag_config_tap jtag_config_tap_asserts chk
(
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tck(tck),
    .trst_n(trst_n),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .nv_cfg(nv_cfg),
    .cfg_data(cfg_data),
    .program_start(program_start),
    .erase_start(erase_start),
    .verify_start(verify_start),
    .active_instr(active_instr),
    .tap_state(tap_state)
);

// [testbench/jtag_host.sv]
// serial programming host: drives tck, tms, tdi and reads the tdo line.
// assumes a pull-up on the tdo line; tck rests low between calls.
`timescale 1ns/1ps
`include "jtag_config_tap_map.vh"
module jtag_host
(
    // pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire tdo,
    input wire tdo_oe
);
    wire line = tdo_oe ? tdo : 1'b1;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 64 ns tck period; tms and tdi move only while tck is low
    task step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #16 q = line;
        tck = 1'b1;
        #32 tck = 1'b0;
        #16;
    endtask
    // scan from idle, lsb first; pz is a pause point, fin the last tms
    task scan(input logic ir, input logic [`CFG_LEN-1:0] d, input int n,
        input int pz, input logic fin, output logic [`CFG_LEN-1:0] q);
        logic b;
        int i;
        q = '0;
        step(1'b1, 1'b0, b);
        if (ir)
            step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (i = 0; i < n; i++)
        begin
            step(i == n - 1 || i == pz, d[i], q[i]);
            if (i == pz && i != n - 1)
            begin
                step(1'b0, 1'b0, b);
                step(1'b0, 1'b0, b);
                step(1'b1, 1'b0, b);
                step(1'b0, 1'b0, b);
            end
        end
        step(1'b1, 1'b0, b);
        step(fin, 1'b0, b);
    endtask
endmodule // jtag_host

// [testbench/test_jtag_config_tap.sv]
// self-checking bench for the configuration test access port.
// assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "jtag_config_tap_map.vh"
module test_jtag_config_tap;
    logic ref_clk, rst_n, trst_n, b;
    logic [`CFG_LEN-1:0] nv_cfg = {1'b1, {27{4'h9}}};
    logic [`CFG_LEN-1:0] pat = {1'b0, {27{4'h3}}};
    logic [`CFG_LEN-1:0] q;
    wire tck, tms, tdi, tdo, tdo_oe, prg, era, ver, cal;
    wire [`CFG_LEN-1:0] cfg_data;
    wire [`IR_LEN-1:0] active_instr;
    wire [`STATE_W-1:0] tap_state;
    int failures, n_compared, n_prg, n_era, n_ver, n_cal;
    jtag_host h(.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    jtag_config_tap dut(.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
        .nv_cfg(nv_cfg), .cfg_data(cfg_data), .program_start(prg),
        .erase_start(era), .verify_start(ver), .calibrate_start(cal),
        .active_instr(active_instr), .tap_state(tap_state));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        n_prg += (prg === 1'b1);
        n_era += (era === 1'b1);
        n_ver += (ver === 1'b1);
        n_cal += (cal === 1'b1);
    end
    task chk(input logic [`CFG_LEN-1:0] got, input logic [`CFG_LEN-1:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task final_report;
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // every code loaded, back to idle through test-logic-reset so deferred ones never start
    task t_codes;
        logic [4:0] c [9] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h0d, 5'h10,
            5'h1e, 5'h1f, 5'h00};
        for (int i = 0; i < 9; i++)
        begin
            h.scan(1'b1, {104'h0, c[i]}, 5, 999, 1'b1, q);
            chk(q[4:0], 5'h0d);
            chk(active_instr, c[i]);
            h.step(1'b1, 1'b0, b);
            h.step(1'b1, 1'b0, b);
            h.step(1'b0, 1'b0, b);
        end
        chk(n_prg + n_era + n_ver + n_cal, 0);
    endtask
    task t_bypass;
        logic [4:0] c [3] = '{5'h00, 5'h1e, 5'h1f};
        for (int i = 0; i < 3; i++)
        begin
            h.scan(1'b1, {104'h0, c[i]}, 5, 999, 1'b0, q);
            h.scan(1'b0, 109'h5, 3, 999, 1'b0, q);
            chk(q[2:0], 3'h2);
        end
        chk(cfg_data, 109'h0);
    endtask
    task t_ops;
        h.scan(1'b1, `SELECT_CONFIG_REG_INSTR, 5, 999, 1'b0, q);
        h.scan(1'b0, pat, `CFG_LEN, 50, 1'b0, q);
        chk(cfg_data, pat);
        h.scan(1'b1, `PROGRAM_CONFIG_INSTR, 5, 999, 1'b0, q);
        chk(n_prg, 1);
        h.scan(1'b1, `VERIFY_CONFIG_INSTR, 5, 999, 1'b0, q);
        chk(n_ver, 1);
        h.scan(1'b1, `SELECT_CONFIG_REG_INSTR, 5, 999, 1'b0, q);
        h.scan(1'b0, 109'h0, `CFG_LEN, 999, 1'b0, q);
        chk(q, nv_cfg);
        h.scan(1'b1, `ERASE_ALL_CONFIG_INSTR, 5, 999, 1'b0, q);
        h.scan(1'b1, `START_CALIBRATION_INSTR, 5, 999, 1'b0, q);
        chk(n_era + n_cal, 2);
    endtask
    task t_resets;
        h.scan(1'b1, `ERASE_ALL_CONFIG_INSTR, 5, 999, 1'b1, q);
        @(negedge ref_clk) trst_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk(tap_state, 4'h0);
        trst_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        h.step(1'b0, 1'b0, b);
        chk(n_era, 1);
        h.step(1'b1, 1'b0, b);
        h.step(1'b0, 1'b0, b);
        h.step(1'b0, 1'b0, b);
        repeat (5) h.step(1'b1, 1'b0, b);
        chk(tap_state, 4'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        trst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk(tap_state, 4'h0);
        h.step(1'b0, 1'b0, b);
        chk(tap_state, 4'h1);
        h.scan(1'b0, 109'h0, 32, 999, 1'b0, q);
        chk(q[31:0], `ID_WORD);
        t_codes;
        t_bypass;
        t_ops;
        t_resets;
        final_report;
    end
    initial
    begin
        #200000;
        failures++;
        final_report;
    end
endmodule // test_jtag_config_tap
